// >>> include/cdu_pkg.sv
// constants, types and carriers of the configuration download/update block
// assumes one 200 MHz clock and a serial front end that hands in whole
// register requests
// Contract
// - each latch has two identical stages
// - start loading only after lockout release
// - power-up load fills first stages first
// - one transfer copies all first stages over
// - wait 0.5 ms, then fetch first state
// - not-acknowledge every access before load done
// - control bit 0 set: writes act immediately
// - bit 0 clear: writes stage only
// - writing 1 to bit 1 commits all
// - nonvolatile writes leave working latches alone
// - reload copies nonvolatile store back in
// - erase sets page ones only when enabled
// - erase enable is bit 2, command FEh
// - reload trigger D8h bit 0 reloads pages
package cdu_pkg;
	localparam int CFG_BYTES  = 224;
	localparam int NVM_BYTES  = 512;
	localparam int PAGE_BYTES = 32;

	localparam logic [15:0] UPD_ADDR    = 16'h0090;
	localparam logic [15:0] RELOAD_ADDR = 16'h00D8;
	localparam logic [15:0] RAM_END     = 16'h00E0;
	localparam logic [15:0] NVM_BASE    = 16'hF800;
	localparam logic [7:0]  CMD_ERASE   = 8'hFE;
	localparam logic [2:0]  UPD_RESET   = 3'h0;

	localparam int UPD_LIVE   = 0;
	localparam int UPD_COMMIT = 1;
	localparam int UPD_ERASE  = 2;
	localparam int RELOAD_BIT = 0;

	localparam real CLK_PERIOD_NS = 5.0;
	localparam real ENGINE_DELAY_MS  = 0.5;
	localparam int  ENGINE_DELAY_CYC =
		int'($ceil(ENGINE_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));

	typedef enum logic [2:0] {
		ST_LOCK  = 3'h0,
		ST_LOAD  = 3'h1,
		ST_XFER  = 3'h3,
		ST_DELAY = 3'h2,
		ST_FETCH = 3'h6,
		ST_RUN   = 3'h7
	} cdu_state_type;

	typedef logic [CFG_BYTES-1:0][7:0] cdu_cfg_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cdu_req_type;

	typedef struct packed {
		logic       ack;
		logic       nack;
		logic [7:0] rdata;
	} cdu_rsp_type;

	typedef struct packed {
		cdu_state_type st;
		logic [7:0]    cnt;
		logic [31:0]   dly;
		logic [2:0]    upd;
		logic          commit;
		logic          done;
		logic          fetch;
		logic          rd_pend;
		cdu_rsp_type   rsp;
		cdu_cfg_type   lat_a;
		cdu_cfg_type   lat_b;
	} cdu_core_type;

	typedef struct packed {
		logic [NVM_BYTES-1:0][7:0] mem;
		logic [7:0]                rdata;
	} cdu_nvm_type;
endpackage

// >>> hdl/cdu_nvm.sv
// nonvolatile configuration store: byte read, byte write, page erase
// assumes contents survive reset; read data come out one cycle later
`timescale 1ns/1ps
module cdu_nvm (
	input  wire logic       clk_i,
	input  wire logic [8:0] rd_addr_i,
	output logic      [7:0] rdata_o,
	input  wire logic       wr_i,
	input  wire logic [8:0] wr_addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       er_i,
	input  wire logic [3:0] er_page_i
);
	import cdu_pkg::*;

	cdu_nvm_type q;
	cdu_nvm_type next_q;

	// no reset on purpose: the store must keep its contents
	always_comb begin
		next_q = q;
		next_q.rdata = q.mem[rd_addr_i];
		if (wr_i) begin
			next_q.mem[wr_addr_i] = wr_data_i;
		end
		// a whole page goes to all ones in one cycle
		if (er_i) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				next_q.mem[{er_page_i, 5'(i)}] = 8'hFF;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		q <= next_q;
	end

	assign rdata_o = q.rdata;
endmodule

// >>> hdl/cdu_top.sv
// configuration loader with double-staged latches and update control
// assumes a serial front end that presents one request per pulse and
// a lockout release level that rises once the supply is good
`timescale 1ns/1ps
module cdu_top #(
	parameter int ENGINE_DELAY_CYC_P = cdu_pkg::ENGINE_DELAY_CYC
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 undervoltage_lockout_release_i,
	input  wire cdu_pkg::cdu_req_type req_i,
	output cdu_pkg::cdu_rsp_type      rsp_o,
	output cdu_pkg::cdu_cfg_type      cfg_active_o,
	output logic                      load_done_o,
	output logic                      sequencing_engine_fetch_o
);
	import cdu_pkg::*;

	cdu_core_type q;
	cdu_core_type next_q;
	logic [8:0]   mem_rd_addr;
	logic [7:0]   mem_rdata;
	logic         mem_wr;
	logic         mem_er;
	logic         is_ram;
	logic         is_nvm;
	logic [7:0]   ram_idx;

	// address decode of the incoming request
	assign is_nvm  = req_i.addr[15:9] == NVM_BASE[15:9];
	assign is_ram  = req_i.addr < RAM_END;
	assign ram_idx = req_i.addr[7:0];

	cdu_nvm u_nvm (
		.clk_i     (clk_i),
		.rd_addr_i (mem_rd_addr),
		.rdata_o   (mem_rdata),
		.wr_i      (mem_wr),
		.wr_addr_i (req_i.addr[8:0]),
		.wr_data_i (req_i.wdata),
		.er_i      (mem_er),
		.er_page_i (req_i.addr[8:5])
	);

	// sequencer, latch stages and request handling
	always_comb begin
		next_q = q;
		next_q.rsp.ack = 1'b0;
		next_q.rsp.nack = 1'b0;
		next_q.fetch = 1'b0;
		next_q.commit = 1'b0;
		mem_rd_addr = req_i.addr[8:0];
		mem_wr = 1'b0;
		mem_er = 1'b0;
		case (q.st)
			ST_LOCK: begin
				if (undervoltage_lockout_release_i) begin
					next_q.st = ST_LOAD;
					next_q.cnt = 8'h00;
				end
			end
			// read data lag one cycle, so byte cnt-1 lands now
			ST_LOAD: begin
				mem_rd_addr = {1'b0, q.cnt};
				if (q.cnt != 8'h00) begin
					next_q.lat_a[8'(q.cnt - 8'h01)] = mem_rdata;
				end
				if (q.cnt == 8'(CFG_BYTES)) begin
					next_q.st = ST_XFER;
				end else begin
					next_q.cnt = q.cnt + 8'h01;
				end
			end
			ST_XFER: begin
				next_q.lat_b = q.lat_a;
				if (q.done) begin
					next_q.st = ST_RUN;
				end else begin
					next_q.done = 1'b1;
					next_q.st = ST_DELAY;
					next_q.dly = 32'h0;
				end
			end
			ST_DELAY: begin
				if (q.dly == 32'(ENGINE_DELAY_CYC_P - 1)) begin
					next_q.st = ST_FETCH;
				end else begin
					next_q.dly = q.dly + 32'h1;
				end
			end
			ST_FETCH: begin
				next_q.fetch = 1'b1;
				next_q.st = ST_RUN;
			end
			ST_RUN: begin
				next_q.st = ST_RUN;
			end
			default: begin
				next_q.st = ST_LOCK;
			end
		endcase

		// commit pulse copies every first stage at once
		if (q.commit) begin
			next_q.lat_b = q.lat_a;
		end

		// store read answers two cycles after the request, one later than other accesses
		if (q.rd_pend) begin
			next_q.rd_pend = 1'b0;
			next_q.rsp.ack = 1'b1;
			next_q.rsp.rdata = mem_rdata;
		end

		// busy outside ST_RUN (lockout, load or reload, transfer, engine delay, fetch) or during a pending store read
		if (req_i.req) begin
			if (q.st != ST_RUN || q.rd_pend) begin
				next_q.rsp.nack = 1'b1;
			end else if (req_i.we && req_i.cmd == CMD_ERASE) begin
				mem_er = q.upd[UPD_ERASE];
				next_q.rsp.ack = 1'b1;
			end else if (req_i.we) begin
				next_q.rsp.ack = 1'b1;
				if (req_i.addr == UPD_ADDR) begin
					next_q.upd = req_i.wdata[2:0];
					next_q.upd[UPD_COMMIT] = 1'b0;
					next_q.commit = req_i.wdata[UPD_COMMIT];
				end else if (req_i.addr == RELOAD_ADDR) begin
					if (req_i.wdata[RELOAD_BIT]) begin
						next_q.st = ST_LOAD;
						next_q.cnt = 8'h00;
					end
				end else if (is_ram) begin
					next_q.lat_a[ram_idx] = req_i.wdata;
					if (q.upd[UPD_LIVE]) begin
						next_q.lat_b[ram_idx] = req_i.wdata;
					end
				end else if (is_nvm) begin
					mem_wr = 1'b1;
				end
			end else if (is_nvm) begin
				next_q.rd_pend = 1'b1;
			end else begin
				next_q.rsp.ack = 1'b1;
				if (req_i.addr == UPD_ADDR) begin
					next_q.rsp.rdata = {5'h00, q.upd};
				end else if (is_ram && req_i.addr != RELOAD_ADDR) begin
					next_q.rsp.rdata = q.lat_a[ram_idx];
				end else begin
					next_q.rsp.rdata = 8'h00;
				end
			end
		end
	end

	// whole state in one register; reset leaves the engine locked out
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.upd <= UPD_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign rsp_o                     = q.rsp;
	assign cfg_active_o              = q.lat_b;
	assign load_done_o               = q.done;
	assign sequencing_engine_fetch_o = q.fetch;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_commit_wr;
		req_i.req && req_i.we && req_i.cmd != CMD_ERASE &&
		req_i.addr == UPD_ADDR && req_i.wdata[UPD_COMMIT] &&
		q.st == ST_RUN && !q.rd_pend;
	endsequence

	sequence s_one_pulse;
		q.commit && !q.upd[UPD_COMMIT] ##1 !q.commit;
	endsequence

	a_nack_early: assert property (
		req_i.req && !q.done |=> q.rsp.nack && !q.rsp.ack)
		else $error("access before load done not refused");

	a_lock_hold: assert property (
		q.st == ST_LOCK && !undervoltage_lockout_release_i
		|=> q.st == ST_LOCK)
		else $error("load started without lockout release");

	a_load_b_stable: assert property (
		q.st == ST_LOAD && !q.commit |=> $stable(q.lat_b))
		else $error("second stage changed during load");

	a_xfer_copy: assert property (
		q.st == ST_XFER |=> q.lat_b === $past(q.lat_a))
		else $error("transfer did not copy first stages");

	a_fetch_after: assert property (
		q.fetch |-> $past(q.st) == ST_FETCH &&
		$past(q.dly, 2) == 32'(ENGINE_DELAY_CYC_P - 1))
		else $error("state fetch without full delay");

	a_live_write: assert property (
		req_i.req && req_i.we && req_i.cmd != CMD_ERASE && is_ram &&
		req_i.addr != UPD_ADDR && req_i.addr != RELOAD_ADDR &&
		q.st == ST_RUN && !q.rd_pend && q.upd[UPD_LIVE]
		|=> q.lat_b[$past(ram_idx)] == $past(req_i.wdata))
		else $error("live write did not reach second stage");

	a_staged_write: assert property (
		req_i.req && req_i.we && !q.upd[UPD_LIVE] && !q.commit &&
		q.st == ST_RUN |=> $stable(q.lat_b))
		else $error("staged write changed active configuration");

	a_commit_pulse: assert property (
		s_commit_wr |=> s_one_pulse)
		else $error("commit did not give exactly one pulse");

	// disabled erase must leave byte 1 of the addressed page as it was
	a_erase_gate: assert property (
		req_i.req && req_i.we && req_i.cmd == CMD_ERASE &&
		q.st == ST_RUN && !q.rd_pend && !q.upd[UPD_ERASE]
		|=> u_nvm.q.mem[{$past(req_i.addr[8:5]), 5'h01}] ==
		$past(u_nvm.q.mem[{req_i.addr[8:5], 5'h01}]))
		else $error("erase changed the store while disabled");

	// enabled erase must set the first and last byte of the addressed page to FFh
	a_erase_fill: assert property (
		req_i.req && req_i.we && req_i.cmd == CMD_ERASE &&
		q.st == ST_RUN && !q.rd_pend && q.upd[UPD_ERASE]
		|=> u_nvm.q.mem[{$past(req_i.addr[8:5]), 5'h00}] == 8'hFF &&
		u_nvm.q.mem[{$past(req_i.addr[8:5]), 5'h1F}] == 8'hFF)
		else $error("enabled erase left page bytes unset");

	a_reload_go: assert property (
		req_i.req && req_i.we && req_i.cmd != CMD_ERASE &&
		req_i.addr == RELOAD_ADDR && req_i.wdata[RELOAD_BIT] &&
		q.st == ST_RUN && !q.rd_pend |=> q.st == ST_LOAD ##225 q.st == ST_XFER)
		else $error("reload did not run a full load");

	a_nvm_wr_keep: assert property (
		mem_wr && !q.commit |=> $stable(q.lat_b) && $stable(q.lat_a))
		else $error("store write touched working latches");
endmodule

// >>> sim/cdu_host_model.sv
// host model: issues single-byte register requests and collects replies
// assumes rsp_i is registered by the block and answers within 4 cycles
`timescale 1ns/1ps
module cdu_host_model (
	input  wire logic             clk_i,
	input  wire cdu_pkg::cdu_rsp_type rsp_i,
	output cdu_pkg::cdu_req_type  req_o
);
	import cdu_pkg::*;

	// idle until the bench asks for a transfer
	initial req_o = '0;

	// one-cycle request pulse, then wait for ack or nack
	task automatic access(
		input  logic        we,
		input  logic [7:0]  cmd,
		input  logic [15:0] a,
		input  logic [7:0]  d,
		output logic        ack,
		output logic        nack,
		output logic [7:0]  rd
	);
		int i;
		@(posedge clk_i);
		req_o <= '{1'b1, we, cmd, a, d};
		@(posedge clk_i);
		// released fields are scrambled so stale values cannot help
		req_o <= '{1'b0, ~we, ~cmd, ~a, ~d};
		ack = 1'b0;
		nack = 1'b0;
		rd = 8'h00;
		for (i = 0; i < 4 && ack !== 1'b1 && nack !== 1'b1; i++) begin
			@(negedge clk_i);
			ack = rsp_i.ack;
			nack = rsp_i.nack;
			rd = rsp_i.rdata;
		end
	endtask
endmodule

// >>> sim/cdu_top_tb_top.sv
// bench for the loader: power-up, erase, staging, commit, live, reload
// assumes the host model is the only driver of the request port
`timescale 1ns/1ps
module cdu_top_tb_top;
	import cdu_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        lockout_ok = 1'b0;
	cdu_req_type req;
	cdu_rsp_type rsp;
	cdu_cfg_type cfg;
	logic        done;
	logic        fetch;
	logic        ack;
	logic        nack;
	logic [7:0]  rd;
	int          n_mismatch = 0;
	int          check_count = 0;

	// short engine delay keeps the run brief
	cdu_top #(.ENGINE_DELAY_CYC_P(20)) u_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i),
		.undervoltage_lockout_release_i(lockout_ok),
		.req_i(req), .rsp_o(rsp), .cfg_active_o(cfg),
		.load_done_o(done), .sequencing_engine_fetch_o(fetch));
	cdu_host_model u_host (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

	// 200 MHz clock
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic conclude();
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// one transfer; a missing answer ends the run
	task automatic x(input logic w, input logic [7:0] c,
		input logic [15:0] a, input logic [7:0] d);
		u_host.access(w, c, a, d, ack, nack, rd);
		if (ack !== 1'b1 && nack !== 1'b1) begin
			chk(1'b0, "no answer");
			conclude();
		end
	endtask

	task automatic t_powerup(input bit known);
		int k;
		bit z;
		rst_n_i <= 1'b0;
		lockout_ok <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		x(1'b1, 8'h00, 16'h0010, 8'h11);
		chk(nack === 1'b1, "early access");
		repeat (30) @(posedge clk_i);
		chk(done === 1'b0 && cfg === '0, "load before release");
		lockout_ok <= 1'b1;
		z = 1'b1;
		for (k = 0; k < 400 && done !== 1'b1; k++) begin
			@(negedge clk_i);
			if (done !== 1'b1 && cfg !== '0)
				z = 1'b0;
		end
		chk(z && done === 1'b1, "working side early");
		if (done !== 1'b1)
			conclude();
		if (known)
			chk(cfg[1] === 8'h5A && cfg[2] === 8'hFF, "loaded");
		for (k = 0; k < 40 && fetch !== 1'b1; k++)
			@(negedge clk_i);
		chk(k >= 19 && k <= 22, "fetch delay");
		@(negedge clk_i);
		chk(fetch === 1'b0, "fetch pulse too long");
	endtask

	task automatic t_erase();
		int k;
		x(1'b1, 8'h00, UPD_ADDR, 8'h04);
		for (k = 0; k < 7; k++)
			x(1'b1, CMD_ERASE, NVM_BASE + 16'(k * 32), 8'h00);
		x(1'b0, 8'h00, NVM_BASE + 16'h0001, 8'h00);
		chk(rd === 8'hFF, "erased");
		x(1'b1, 8'h00, NVM_BASE + 16'h0001, 8'h5A);
		x(1'b1, 8'h00, UPD_ADDR, 8'h00);
		x(1'b1, CMD_ERASE, NVM_BASE, 8'h00);
		x(1'b0, 8'h00, NVM_BASE + 16'h0001, 8'h00);
		chk(rd === 8'h5A, "erase not blocked");
	endtask

	task automatic t_stage();
		x(1'b1, 8'h00, 16'h0010, 8'hA5);
		x(1'b0, 8'h00, 16'h0010, 8'h00);
		chk(rd === 8'hA5 && cfg[16] === 8'hFF, "staged");
		x(1'b1, 8'h00, UPD_ADDR, 8'h02);
		chk(cfg[16] === 8'hFF, "commit acted early");
		repeat (2) @(negedge clk_i);
		chk(cfg[16] === 8'hA5, "commit");
		x(1'b0, 8'h00, UPD_ADDR, 8'h00);
		chk(rd === 8'h00, "commit bit stuck");
	endtask

	task automatic t_reload();
		int k;
		x(1'b1, 8'h00, UPD_ADDR, 8'h01);
		x(1'b1, 8'h00, 16'h0020, 8'h3C);
		chk(cfg[32] === 8'h3C, "live write");
		x(1'b1, 8'h00, NVM_BASE + 16'h0020, 8'hC3);
		chk(cfg[32] === 8'h3C, "store write leaked");
		x(1'b1, 8'h00, RELOAD_ADDR, 8'h01);
		x(1'b0, 8'h00, 16'h0020, 8'h00);
		chk(nack === 1'b1, "access during reload");
		for (k = 0; k < 300 && cfg[32] !== 8'hC3; k++)
			@(negedge clk_i);
		chk(cfg[32] === 8'hC3 && cfg[16] === 8'hFF, "reload");
	endtask

	// second power-up reuses the store written after the first one
	initial begin
		t_powerup(1'b0);
		t_erase();
		@(posedge clk_i);
		t_powerup(1'b1);
		t_stage();
		t_reload();
		conclude();
	end
endmodule
